//--- logic/tx_test_pkg.sv
// Constants, register map and state codes for the radio transmit test-pattern block.
// Assumes a single system clock and an APB master on the processor side.
// Behaviour
// - Mode 2, DAC override 0x1800 and transmit-on force static DACs: unmodulated carrier.
// - Mode 3 with transmit-on sends a CRC-generated pseudorandom pattern, not user data.
// - Each CRC-mode byte is the CRC low byte; CRC then advances with 0xFF.
// - The CRC pseudorandom sequence repeats every 32767 bytes.
// - CRC payload starts 0x00, 0x78, 0xb8, 0x4b, 0x99, 0xc3, 0xe9 after the header.
// - Every transmit mode sends preamble and start delimiter ahead of the data.
// - Mode 2 repeats the transmit buffer contents, ignoring underflow: 1024-bit sequence.
// - Bias switch output is low while receiving and high while transmitting.
package tx_test_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_MODEM_CTRL = 8'h00; // modem_control_one_low
	localparam logic [7:0] OFS_DAC_HIGH = 8'h04; // dac_override_high
	localparam logic [7:0] OFS_DAC_LOW = 8'h08; // dac_override_low
	localparam logic [7:0] OFS_COMMAND = 8'h0c; // command strobes
	localparam logic [7:0] OFS_TX_BUFFER = 8'h10; // transmit_buffer push
	localparam logic [7:0] OFS_STATUS = 8'h14; // status

	// Field positions
	localparam int TX_MODE_LSB = 0;
	localparam int RX_MODE_LSB = 2;
	localparam int CMD_TX_ON = 0;
	localparam int CMD_RF_OFF = 1;
	localparam int CMD_FLUSH = 2;
	localparam int ST_ACTIVE = 0;
	localparam int ST_UNDERFLOW = 1;
	localparam int ST_XOSC = 2;
	localparam int ST_COUNT_LSB = 8;

	// Transmit mode encodings
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_BUFFER_LOOP = 2'h2;
	localparam logic [1:0] MODE_CRC_RANDOM = 2'h3;

	// Reset values and pattern constants
	localparam logic [3:0] MODEM_CTRL_RESET = 4'h0;
	localparam logic [7:0] DAC_RESET = 8'h00;
	localparam logic [15:0] DAC_CARRIER = 16'h1800;
	localparam logic [7:0] CRC_FEED = 8'hff;
	localparam logic [15:0] CRC_POLY_REFLECTED = 16'h8408;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [7:0] PREAMBLE_BYTE = 8'h00;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_header = 2'b01,
		st_payload = 2'b10
	} tx_state_e;
endpackage : tx_test_pkg

//--- logic/crc_pattern_gen.sv
// CRC-16 generator used as the pseudorandom source in CRC test mode.
// Assumes the caller pulses init before the first byte and step per byte sent.
`timescale 1ns/1ps
`default_nettype none
module crc_pattern_gen
	import tx_test_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic init, // Restart the sequence
	input wire logic step, // Advance by one byte
	output logic [7:0] low_byte, // Current CRC low byte
	output logic [7:0] next_low_byte // Low byte after the next step
);
	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic fresh_q;

	// LSB-first CRC advance over one byte
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ b[i]) begin
				r = (r >> 1) ^ CRC_POLY_REFLECTED;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction : crc_byte

	// Constant feed keeps the state on one long cycle
	assign crc_d = crc_byte(crc_q, CRC_FEED);
	assign low_byte = crc_q[7:0];
	assign next_low_byte = crc_d[7:0];

	// CRC state
	always_ff @(posedge clock) begin
		if (!resetn || init) begin
			crc_q <= CRC_INIT;
		end else if (step) begin
			crc_q <= crc_d;
		end
	end

	// No step taken since restart; lets the check catch the first step however late it comes
	always_ff @(posedge clock) begin
		if (!resetn || init) begin
			fresh_q <= 1'b1;
		end else if (step) begin
			fresh_q <= 1'b0;
		end
	end

	// Opening bytes of the sequence
	sequence fresh_step_s;
		fresh_q && step && !init;
	endsequence
	property opening_bytes_p;
		@(posedge clock) disable iff (!resetn)
		(init |=> low_byte == 8'h00) and (fresh_step_s |=> low_byte == 8'h78);
	endproperty
	crc_opening_bytes_a: assert property (opening_bytes_p) else $error("crc pattern does not open 00 78");
	crc_hold_a: assert property (@(posedge clock) disable iff (!resetn)
		(!step && !init) |=> $stable(low_byte)) else $error("crc moved without step");
endmodule : crc_pattern_gen
`default_nettype wire

//--- logic/radio_tx_test_pattern.sv
// Transmit test-mode logic: APB registers, transmit buffer, header and payload byte stream.
// Assumes the front end takes a byte when tx_valid and tx_ready are both high.
`timescale 1ns/1ps
`default_nettype none
module radio_tx_test_pattern
	import tx_test_pkg::*;
#(
	parameter int BUF_DEPTH = 128, // Transmit buffer bytes
	parameter int PREAMBLE_LEN = 4, // Preamble bytes
	parameter logic [7:0] SFD_BYTE = 8'ha7 // Start-of-frame delimiter byte
)(
	input wire logic clock, // System clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic xosc_stable, // Crystal oscillator settled
	output logic [7:0] tx_data, // Byte to front end
	output logic tx_valid, // Byte offered
	input wire logic tx_ready, // Front end takes byte
	output logic dac_force, // Hold I/Q DACs static
	output logic [15:0] dac_value, // Static DAC word
	output logic rx_tx_bias_switch // High in transmit, low in receive
);
	localparam int PW = $clog2(BUF_DEPTH);
	localparam logic [PW:0] DEPTH_CNT = BUF_DEPTH[PW:0];
	localparam logic [3:0] HDR_LAST = PREAMBLE_LEN[3:0];

	// Refuse sizes that the pointers and the header counter cannot serve
	if (BUF_DEPTH < 2 || (1 << PW) != BUF_DEPTH) begin : g_bad_depth
		$error("BUF_DEPTH must be a power of two, at least 2");
	end
	if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 14) begin : g_bad_preamble
		$error("PREAMBLE_LEN must be 1 to 14");
	end

	logic [3:0] modem_ctrl_q;
	logic [7:0] dac_high_q;
	logic [7:0] dac_low_q;
	logic [7:0] mem [BUF_DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	logic underflow_q;
	tx_state_e state_q;
	logic [1:0] mode_q;
	logic [3:0] hdr_idx_q;
	logic [7:0] tx_data_q;
	logic dac_force_q;
	logic bias_q;
	logic [31:0] prdata_q;
	logic crc_init;
	logic crc_step;
	logic [7:0] crc_low;
	logic [7:0] crc_next_low;

	// APB decode
	logic setup_ph, access_wr, mapped;
	logic cmd_tx_on, cmd_rf_off, cmd_flush, push, pop, taken, hdr_done;
	logic start, empty_at_payload, last_normal;
	assign setup_ph = psel && !penable;
	assign access_wr = psel && penable && pwrite;
	assign mapped = (paddr == OFS_MODEM_CTRL) || (paddr == OFS_DAC_HIGH) || (paddr == OFS_DAC_LOW) ||
		(paddr == OFS_COMMAND) || (paddr == OFS_TX_BUFFER) || (paddr == OFS_STATUS);
	assign pready = 1'b1; // Read data is captured in setup, so no wait states
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_q;

	// Command strobes and buffer handshake terms
	assign cmd_tx_on = access_wr && paddr == OFS_COMMAND && pwdata[CMD_TX_ON];
	assign cmd_rf_off = access_wr && paddr == OFS_COMMAND && pwdata[CMD_RF_OFF];
	assign cmd_flush = access_wr && paddr == OFS_COMMAND && pwdata[CMD_FLUSH];
	assign push = access_wr && paddr == OFS_TX_BUFFER && count_q != DEPTH_CNT && !cmd_flush;
	assign taken = tx_valid && tx_ready;
	assign hdr_done = state_q == st_header && taken && hdr_idx_q == HDR_LAST;
	assign start = state_q == st_idle && cmd_tx_on && !cmd_rf_off;
	assign empty_at_payload = hdr_done && mode_q != MODE_BUFFER_LOOP && mode_q != MODE_CRC_RANDOM && count_q == '0;
	assign last_normal = state_q == st_payload && taken && mode_q != MODE_BUFFER_LOOP &&
		mode_q != MODE_CRC_RANDOM && count_q == {{PW{1'b0}}, 1'b1};
	// Loop mode reads without consuming, so the buffer never runs dry
	assign pop = state_q == st_payload && taken &&
		mode_q != MODE_BUFFER_LOOP && mode_q != MODE_CRC_RANDOM;
	assign crc_init = start;
	assign crc_step = state_q == st_payload && taken && mode_q == MODE_CRC_RANDOM;

	assign tx_valid = state_q != st_idle;
	assign tx_data = tx_data_q;
	assign dac_force = dac_force_q;
	assign dac_value = {dac_high_q, dac_low_q};
	assign rx_tx_bias_switch = bias_q;

	// Configuration registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			modem_ctrl_q <= MODEM_CTRL_RESET;
			dac_high_q <= DAC_RESET;
			dac_low_q <= DAC_RESET;
		end else if (access_wr) begin
			if (paddr == OFS_MODEM_CTRL) begin
				modem_ctrl_q <= pwdata[3:0];
			end
			if (paddr == OFS_DAC_HIGH) begin
				dac_high_q <= pwdata[7:0];
			end
			if (paddr == OFS_DAC_LOW) begin
				dac_low_q <= pwdata[7:0];
			end
		end
	end

	// Read data captured in setup phase so prdata comes from a flop
	always_ff @(posedge clock) begin
		if (!resetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata_q <= 32'h0000_0000;
			case (paddr)
				OFS_MODEM_CTRL: prdata_q[3:0] <= modem_ctrl_q;
				OFS_DAC_HIGH: prdata_q[7:0] <= dac_high_q;
				OFS_DAC_LOW: prdata_q[7:0] <= dac_low_q;
				OFS_STATUS: begin
					prdata_q[ST_ACTIVE] <= state_q != st_idle;
					prdata_q[ST_UNDERFLOW] <= underflow_q;
					prdata_q[ST_XOSC] <= xosc_stable;
					prdata_q[ST_COUNT_LSB +: PW+1] <= count_q;
				end
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Buffer storage has no reset; pointers define what is valid
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr_q] <= pwdata[7:0];
		end
	end

	// Buffer pointers and fill count
	always_ff @(posedge clock) begin
		if (!resetn || cmd_flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (state_q == st_payload && taken && mode_q != MODE_CRC_RANDOM) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

	// Underflow flag; a new event wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (!resetn) begin
			underflow_q <= 1'b0;
		end else if (empty_at_payload || last_normal) begin
			underflow_q <= 1'b1;
		end else if (access_wr && paddr == OFS_STATUS && pwdata[ST_UNDERFLOW]) begin
			underflow_q <= 1'b0;
		end
	end

	// Transmit sequencer: header first in every mode, then payload unless the buffer is empty outside loop and CRC modes
	always_ff @(posedge clock) begin
		if (!resetn) begin
			state_q <= st_idle;
			mode_q <= MODE_NORMAL;
			hdr_idx_q <= '0;
			tx_data_q <= 8'h00;
		end else if (cmd_rf_off) begin
			state_q <= st_idle;
		end else begin
			case (state_q)
				st_idle: begin
					if (start) begin
						state_q <= st_header;
						mode_q <= modem_ctrl_q[TX_MODE_LSB +: 2];
						hdr_idx_q <= '0;
						tx_data_q <= PREAMBLE_BYTE;
					end
				end
				st_header: begin
					if (taken) begin
						hdr_idx_q <= hdr_idx_q + 1'b1;
						if (hdr_idx_q == HDR_LAST - 4'h1) begin
							tx_data_q <= SFD_BYTE;
						end else if (hdr_done) begin
							if (empty_at_payload) begin
								state_q <= st_idle;
							end else begin
								state_q <= st_payload;
							end
							if (mode_q == MODE_CRC_RANDOM) begin
								tx_data_q <= crc_low;
							end else begin
								tx_data_q <= mem[rd_ptr_q];
							end
						end else begin
							tx_data_q <= PREAMBLE_BYTE;
						end
					end
				end
				st_payload: begin
					if (taken) begin
						if (last_normal) begin
							state_q <= st_idle;
						end
						if (mode_q == MODE_CRC_RANDOM) begin
							tx_data_q <= crc_next_low;
						end else begin
							tx_data_q <= mem[rd_ptr_q + 1'b1];
						end
					end
				end
				default: state_q <= st_idle;
			endcase
		end
	end

	// DAC override and bias switch follow the transmitter state
	always_ff @(posedge clock) begin
		if (!resetn) begin
			dac_force_q <= 1'b0;
			bias_q <= 1'b0;
		end else begin
			dac_force_q <= (start || (state_q != st_idle && !cmd_rf_off && !empty_at_payload && !last_normal)) &&
				(start ? modem_ctrl_q[TX_MODE_LSB +: 2] : mode_q) == MODE_BUFFER_LOOP &&
				{dac_high_q, dac_low_q} == DAC_CARRIER;
			bias_q <= start || (state_q != st_idle && !cmd_rf_off && !empty_at_payload && !last_normal);
		end
	end

	crc_pattern_gen u_crc (
		.clock(clock),
		.resetn(resetn),
		.init(crc_init),
		.step(crc_step),
		.low_byte(crc_low),
		.next_low_byte(crc_next_low)
	);

	// Checks on the transmitter
	sequence header_end_s;
		hdr_done && !cmd_rf_off && mode_q == MODE_CRC_RANDOM;
	endsequence
	bias_in_tx_a: assert property (@(posedge clock) disable iff (!resetn)
		tx_valid |-> rx_tx_bias_switch) else $error("bias switch low while transmitting");
	bias_in_rx_a: assert property (@(posedge clock) disable iff (!resetn)
		!tx_valid |-> !rx_tx_bias_switch) else $error("bias switch high while idle");
	carrier_force_a: assert property (@(posedge clock) disable iff (!resetn)
		dac_force |-> tx_valid && mode_q == MODE_BUFFER_LOOP && dac_value == DAC_CARRIER)
		else $error("dac override outside carrier mode");
	header_first_a: assert property (@(posedge clock) disable iff (!resetn)
		start |=> state_q == st_header && tx_data == PREAMBLE_BYTE && hdr_idx_q == 4'h0)
		else $error("transmission did not open with preamble");
	crc_payload_a: assert property (@(posedge clock) disable iff (!resetn)
		header_end_s |=> state_q == st_payload && tx_data == 8'h00) else $error("crc payload start wrong");
	crc_byte_a: assert property (@(posedge clock) disable iff (!resetn)
		(state_q == st_payload && mode_q == MODE_CRC_RANDOM) |-> tx_data == crc_low)
		else $error("crc mode byte is not crc low byte");
	loop_no_end_a: assert property (@(posedge clock) disable iff (!resetn)
		(state_q == st_payload && mode_q == MODE_BUFFER_LOOP && taken && !cmd_rf_off)
		|=> state_q == st_payload && rd_ptr_q == $past(rd_ptr_q) + 1'b1 && !$rose(underflow_q))
		else $error("buffer loop mode stopped or flagged underflow");
	normal_plain_a: assert property (@(posedge clock) disable iff (!resetn)
		(state_q == st_payload && mode_q == MODE_NORMAL) |-> !dac_force && !crc_step)
		else $error("normal mode used override or pattern");
endmodule : radio_tx_test_pattern
`default_nettype wire

//--- test/front_end_model.sv
// Behavioural RF front end: takes stream bytes unless the bench stalls it.
// Assumes the bench supplies the stall pattern on hold, changed just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
	input wire logic hold, // Stall request
	input wire logic tx_valid, // Byte offered
	input wire logic [7:0] tx_data, // Offered byte
	output logic tx_ready, // Front end can take
	output logic byte_taken, // Handshake this cycle
	output logic [7:0] taken_byte // Byte taken
);
	// Ready drops while stalled, so the block must hold its byte
	assign tx_ready = ~hold;
	assign byte_taken = tx_valid & tx_ready;
	assign taken_byte = tx_data;
endmodule : front_end_model
`default_nettype wire

//--- test/radio_tx_test_pattern_tb.sv
// Self-checking bench for the transmit test-pattern block, with a queue model of the byte stream.
// Assumes zero-wait APB slave and a front end model that stalls at random.
`timescale 1ns/1ps
`default_nettype none
module radio_tx_test_pattern_tb;
	import tx_test_pkg::*;
	localparam int DEPTH = 8;
	localparam int PRE = 4;
	localparam logic [7:0] SFD = 8'h3c;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic xosc_stable = 1'b0;
	logic hold = 1'b0;
	logic [7:0] hold_q = 8'h28;
	logic [31:0] prdata;
	logic pready, pslverr, tx_valid, tx_ready, dac_force, rx_tx_bias_switch, byte_taken;
	logic [7:0] tx_data, taken_byte;
	logic [15:0] dac_value;
	logic [7:0] rx_q[$];
	logic [7:0] exp_q[$];
	logic [7:0] mem_q[$];
	logic [31:0] rd;
	logic err;
	logic [7:0] seed;
	logic [15:0] crc;
	int errors = 0;
	int checks = 0;
	int i;
	int p;

	// Free-running clock
	always #12.5 clock = ~clock;

	radio_tx_test_pattern #(.BUF_DEPTH(DEPTH), .PREAMBLE_LEN(PRE), .SFD_BYTE(SFD)) u_dut (
		.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.xosc_stable(xosc_stable), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.dac_force(dac_force), .dac_value(dac_value), .rx_tx_bias_switch(rx_tx_bias_switch));

	front_end_model u_front (.hold(hold), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.byte_taken(byte_taken), .taken_byte(taken_byte));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	// Reflected CRC step fed with all ones
	function automatic logic [15:0] crc_step(input logic [15:0] c);
		logic [15:0] x;
		x = c ^ 16'h00ff;
		for (int b = 0; b < 8; b++) x = x[0] ? ((x >> 1) ^ 16'h8408) : (x >> 1);
		return x;
	endfunction : crc_step

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		if (errors == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim

	// One APB transfer; waits on pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) check(32'(k), 32'h0);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Start a transfer, compare header and n payload bytes, then stop the transmitter
	task automatic run(input int n, input logic force_exp);
		int k;
		exp_q.push_front(SFD);
		repeat (PRE) exp_q.push_front(8'h00);
		rx_q.delete();
		apb(1'b1, OFS_COMMAND, 32'h1);
		// Override state is looked at while the transmitter is surely still running
		@(posedge clock);
		check({31'h0, dac_force}, {31'h0, force_exp});
		k = 0;
		while (rx_q.size() < n + PRE + 1 && k < 4000) begin
			@(posedge clock);
			k++;
		end
		for (k = 0; k < n + PRE + 1; k++) check({24'h0, rx_q[k]}, {24'h0, exp_q[k]});
		check({31'h0, dac_force}, {31'h0, force_exp});
		apb(1'b1, OFS_COMMAND, 32'h2);
		repeat (2) @(posedge clock);
		check({30'h0, tx_valid, rx_tx_bias_switch}, 32'h0);
		exp_q.delete();
	endtask : run

	// Random stalls of the front end
	always @(posedge clock) begin
		hold_q <= lfsr(hold_q);
		hold <= hold_q[0] & hold_q[2];
	end

	// Collect taken bytes; bias must be up whenever a byte is offered
	always @(posedge clock) begin
		if (byte_taken === 1'b1) rx_q.push_back(taken_byte);
		if (resetn === 1'b1 && tx_valid === 1'b1) check({31'h0, rx_tx_bias_switch}, 32'h1);
	end

	// Watchdog, well beyond the expected run length
	initial begin
		#(25 * 60000);
		errors++;
		end_sim();
	end

	initial begin
		seed = 8'h28;
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		xosc_stable <= 1'b1;
		for (i = 0; i < 3; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check(rd, 32'h0);
		end
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h4);
		apb(1'b0, 8'h20, 32'h0);
		check({err, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, OFS_MODEM_CTRL, 32'hffff_ffff);
		apb(1'b0, OFS_MODEM_CTRL, 32'h0);
		check(rd, 32'hf);
		// Normal mode ignores a carrier DAC word and ends on an empty buffer
		apb(1'b1, OFS_DAC_HIGH, 32'h18);
		apb(1'b1, OFS_DAC_LOW, 32'h0);
		apb(1'b1, OFS_MODEM_CTRL, {30'h0, MODE_NORMAL});
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			exp_q.push_back(seed);
			apb(1'b1, OFS_TX_BUFFER, {24'h0, seed});
		end
		run(3, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'h3, 32'h2);
		apb(1'b1, OFS_STATUS, 32'h2);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'h3, 32'h0);
		// Empty buffer: header only, then idle with underflow flagged
		run(0, 1'b0);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(rd & 32'h3, 32'h2);
		// Pseudorandom mode against the bench CRC
		apb(1'b1, OFS_MODEM_CTRL, {30'h0, MODE_CRC_RANDOM});
		crc = 16'h0;
		for (i = 0; i < 40; i++) begin
			exp_q.push_back(crc[7:0]);
			crc = crc_step(crc);
		end
		run(40, 1'b0);
		// Buffer loop, with and without the carrier DAC word
		for (p = 0; p < 2; p++) begin
			apb(1'b0, OFS_STATUS, 32'h0);
			check({31'h0, rd[ST_ACTIVE]}, 32'h0);
			apb(1'b1, OFS_DAC_LOW, 32'(p));
			apb(1'b1, OFS_COMMAND, 32'h4);
			mem_q.delete();
			for (i = 0; i <= DEPTH; i++) begin
				seed = lfsr(seed);
				if (i < DEPTH) mem_q.push_back(seed);
				apb(1'b1, OFS_TX_BUFFER, {24'h0, seed});
			end
			apb(1'b0, OFS_STATUS, 32'h0);
			check({24'h0, rd[15:8]}, 32'(DEPTH));
			apb(1'b1, OFS_MODEM_CTRL, {30'h0, MODE_BUFFER_LOOP});
			for (i = 0; i < 3 * DEPTH; i++) exp_q.push_back(mem_q[i % DEPTH]);
			run(3 * DEPTH, p == 0);
			check({16'h0, dac_value}, 32'h1800 | 32'(p));
		end
		end_sim();
	end
endmodule : radio_tx_test_pattern_tb
`default_nettype wire
